// file: hdl/lcs_defs.vh
// Register offsets, field positions, reset values and timing counts of the card sense threshold unit.
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LCS_OFS_OPTIONS     8'h3a
`define LCS_OFS_QUAD_LOWER  8'h3f
`define LCS_OFS_QUAD_UPPER  8'h40
`define LCS_OFS_INPH_LOWER  8'h41
`define LCS_OFS_INPH_RESULT 8'h42
`define LCS_OFS_QUAD_RESULT 8'h43

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCS_BIT_FULL_DRIVE  3
`define LCS_BIT_FILTER      2
`define LCS_BIT_Q_UNSTABLE  1
`define LCS_BIT_I_UNSTABLE  0
`define LCS_BIT_SUPPRESS    6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCS_RST_BORDER      8'h00
`define LCS_RST_OPTIONS     2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define LCS_CLK_MHZ         250
`define LCS_SAMPLE_MAX_NS   4720
`define LCS_SAMPLE_MAX_CYC  ((`LCS_SAMPLE_MAX_NS * `LCS_CLK_MHZ) / 1000)

`endif

// file: hdl/lcs_filter.v
// Noise filter and instability detector for one six-bit measurement channel.
`timescale 1ns/1ps
module lcs_filter (
	// Clock and reset
	input  wire       clk,
	input  wire       rst_n,
	// Control
	input  wire       start,
	input  wire       smp_valid,
	input  wire [5:0] smp,
	// Result
	output reg  [5:0] filt_reg,
	output reg        unstable_reg
);
	reg        first_reg;
	reg  [5:0] last_reg;
	wire [6:0] sum = {1'b0, filt_reg} + {1'b0, smp};

	// Running average of two; a changing sample marks the channel unstable.
	always @(posedge clk) begin
		if (!rst_n) begin
			filt_reg     <= 6'h00;
			last_reg     <= 6'h00;
			first_reg    <= 1'b1;
			unstable_reg <= 1'b0;
		end else if (start) begin
			first_reg    <= 1'b1;
			unstable_reg <= 1'b0;
		end else if (smp_valid) begin
			first_reg <= 1'b0;
			last_reg  <= smp;
			filt_reg  <= first_reg ? smp : sum[6:1];
			if (!first_reg && smp != last_reg)
				unstable_reg <= 1'b1;
		end
	end
endmodule

// file: hdl/lcs_threshold_unit.v
// Card sense threshold evaluation, result latching and register file.
`timescale 1ns/1ps
`include "lcs_defs.vh"
module lcs_threshold_unit #(
	parameter NEW_VARIANT = 1
) (
	// Clock and reset
	input  wire       SYS_CLK,
	input  wire       RSTN,
	// Register port
	input  wire [7:0] REG_ADDR,
	input  wire       REG_WR,
	input  wire       REG_RD,
	input  wire [7:0] REG_WDATA,
	output reg  [7:0] REG_RDATA,
	// Measurement front end
	input  wire       MEAS_START,
	input  wire       MEAS_SAMPLE,
	input  wire [5:0] MEAS_I,
	input  wire [5:0] MEAS_Q,
	input  wire       MEAS_DONE,
	// Status and drive
	output reg        CARD_SENSE_IRQ_FLAG,
	input  wire       IRQ_FLAG_CLR,
	output reg        FULL_DRIVE_DURING_DETECT,
	output reg        SAMPLE_OVERRUN
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg  [3:0]  sy1_reg;
	reg  [3:0]  sy2_reg;
	reg  [11:0] dat1_reg;
	reg  [11:0] dat2_reg;
	reg         start_d_reg;
	reg         done_d_reg;
	reg         smp_d_reg;
	wire        start_p = sy2_reg[0] & ~start_d_reg;
	wire        done_p  = sy2_reg[1] & ~done_d_reg;
	wire        smp_p   = sy2_reg[2] & ~smp_d_reg;
	wire        clr_lvl = sy2_reg[3];
	wire [5:0]  i_s     = dat2_reg[5:0];
	wire [5:0]  q_s     = dat2_reg[11:6];

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			sy1_reg     <= 4'h0;
			sy2_reg     <= 4'h0;
			dat1_reg    <= 12'h000;
			dat2_reg    <= 12'h000;
			start_d_reg <= 1'b0;
			done_d_reg  <= 1'b0;
			smp_d_reg   <= 1'b0;
		end else begin
			sy1_reg     <= {IRQ_FLAG_CLR, MEAS_SAMPLE, MEAS_DONE, MEAS_START};
			sy2_reg     <= sy1_reg;
			dat1_reg    <= {MEAS_Q, MEAS_I};
			dat2_reg    <= dat1_reg;
			start_d_reg <= sy2_reg[0];
			done_d_reg  <= sy2_reg[1];
			smp_d_reg   <= sy2_reg[2];
		end
	end

	// ----------------------------------------
	// Filters
	// ----------------------------------------
	wire [5:0] i_filt;
	wire [5:0] q_filt;
	wire       i_unst;
	wire       q_unst;

	lcs_filter u_filt_i (
		.clk          (SYS_CLK),
		.rst_n        (RSTN),
		.start        (start_p),
		.smp_valid    (smp_p),
		.smp          (i_s),
		.filt_reg     (i_filt),
		.unstable_reg (i_unst)
	);

	lcs_filter u_filt_q (
		.clk          (SYS_CLK),
		.rst_n        (RSTN),
		.start        (start_p),
		.smp_valid    (smp_p),
		.smp          (q_s),
		.filt_reg     (q_filt),
		.unstable_reg (q_unst)
	);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0]  quad_lower_reg;
	reg  [7:0]  quad_upper_reg;
	reg  [7:0]  inph_lower_reg;
	reg  [5:0]  inph_result_reg;
	reg  [5:0]  quad_result_reg;
	reg         suppress_reg;
	reg         filter_en_reg;
	reg  [15:0] smp_cnt_reg;
	wire        opt_on     = (NEW_VARIANT != 0);
	wire [31:0] smp_limit  = `LCS_SAMPLE_MAX_CYC;

	// ----------------------------------------
	// Threshold decision
	// ----------------------------------------
	// The three upper bit pairs build the in-phase upper border, highest pair first.
	wire [5:0]  inph_upper = {quad_lower_reg[7:6], quad_upper_reg[7:6], inph_lower_reg[7:6]};
	// With the filter off the synchronised live values are judged directly.
	wire [5:0]  i_eval     = filter_en_reg ? i_filt : i_s;
	wire [5:0]  q_eval     = filter_en_reg ? q_filt : q_s;
	wire        i_above    = (i_eval > inph_upper);
	wire        q_above    = (q_eval > quad_upper_reg[5:0]);
	wire        i_below    = (i_eval < inph_lower_reg[5:0]);
	wire        hit        = i_above | q_above | i_below;
	// A suppress write in the completion cycle already blocks that completion.
	wire        sup_wr     = REG_WR && (REG_ADDR == `LCS_OFS_QUAD_RESULT) && REG_WDATA[`LCS_BIT_SUPPRESS];
	wire        irq_set    = done_p && hit && !suppress_reg && !sup_wr;

	// ----------------------------------------
	// Threshold and option registers
	// ----------------------------------------
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			quad_lower_reg           <= `LCS_RST_BORDER;
			quad_upper_reg           <= `LCS_RST_BORDER;
			inph_lower_reg           <= `LCS_RST_BORDER;
			filter_en_reg            <= 1'b0;
			FULL_DRIVE_DURING_DETECT <= 1'b0;
		end else if (REG_WR) begin
			case (REG_ADDR)
			`LCS_OFS_QUAD_LOWER: quad_lower_reg <= REG_WDATA;
			`LCS_OFS_QUAD_UPPER: quad_upper_reg <= REG_WDATA;
			`LCS_OFS_INPH_LOWER: inph_lower_reg <= REG_WDATA;
			`LCS_OFS_OPTIONS: begin
				// The older variant keeps this address reserved, so its writes are dropped.
				if (opt_on) begin
					FULL_DRIVE_DURING_DETECT <= REG_WDATA[`LCS_BIT_FULL_DRIVE];
					filter_en_reg            <= REG_WDATA[`LCS_BIT_FILTER];
				end
			end
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt suppress
	// ----------------------------------------
	// A measurement start clears the suppress bit, even against a write in the same cycle.
	always @(posedge SYS_CLK) begin
		if (!RSTN)
			suppress_reg <= 1'b0;
		else if (start_p)
			suppress_reg <= 1'b0;
		else if (REG_WR && REG_ADDR == `LCS_OFS_QUAD_RESULT)
			suppress_reg <= REG_WDATA[`LCS_BIT_SUPPRESS];
	end

	// ----------------------------------------
	// Sample time supervision
	// ----------------------------------------
	// The counter saturates so that a stalled front end cannot wrap it back below the limit.
	always @(posedge SYS_CLK) begin
		if (!RSTN)
			smp_cnt_reg <= 16'h0000;
		else if (start_p)
			smp_cnt_reg <= 16'h0000;
		else if (smp_cnt_reg != 16'hffff)
			smp_cnt_reg <= smp_cnt_reg + 16'h0001;
	end

	// ----------------------------------------
	// Results
	// ----------------------------------------
	// Results and the overrun flag change only when a measurement completes.
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			inph_result_reg <= 6'h00;
			quad_result_reg <= 6'h00;
			SAMPLE_OVERRUN  <= 1'b0;
		end else if (done_p) begin
			inph_result_reg <= i_eval;
			quad_result_reg <= q_eval;
			SAMPLE_OVERRUN  <= ({16'h0000, smp_cnt_reg} > smp_limit);
		end
	end

	// ----------------------------------------
	// Interrupt flag
	// ----------------------------------------
	// A new hit wins over a clear in the same cycle, so no event is lost.
	always @(posedge SYS_CLK) begin
		if (!RSTN)
			CARD_SENSE_IRQ_FLAG <= 1'b0;
		else if (irq_set)
			CARD_SENSE_IRQ_FLAG <= 1'b1;
		else if (clr_lvl)
			CARD_SENSE_IRQ_FLAG <= 1'b0;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always @(posedge SYS_CLK) begin
		if (!RSTN)
			REG_RDATA <= 8'h00;
		else if (REG_RD) begin
			case (REG_ADDR)
			`LCS_OFS_QUAD_LOWER:  REG_RDATA <= quad_lower_reg;
			`LCS_OFS_QUAD_UPPER:  REG_RDATA <= quad_upper_reg;
			`LCS_OFS_INPH_LOWER:  REG_RDATA <= inph_lower_reg;
			`LCS_OFS_INPH_RESULT: REG_RDATA <= {2'h0, inph_result_reg};
			`LCS_OFS_QUAD_RESULT: REG_RDATA <= {1'b0, suppress_reg, quad_result_reg};
			`LCS_OFS_OPTIONS:     REG_RDATA <= opt_on ?
				{4'h0, FULL_DRIVE_DURING_DETECT, filter_en_reg, q_unst, i_unst} : 8'h00;
			default:              REG_RDATA <= 8'h00;
			endcase
		end
	end
endmodule

// file: verif/lcs_threshold_unit_sva.sv
// Port checker for the card sense threshold unit.
`timescale 1ns/1ps
module lcs_chk #(
	parameter NEW_VARIANT = 1
) (
	input wire       SYS_CLK,
	input wire       RSTN,
	input wire [7:0] REG_ADDR,
	input wire       REG_WR,
	input wire       REG_RD,
	input wire [7:0] REG_WDATA,
	input wire [7:0] REG_RDATA,
	input wire       MEAS_DONE,
	input wire       CARD_SENSE_IRQ_FLAG,
	input wire       IRQ_FLAG_CLR,
	input wire       FULL_DRIVE_DURING_DETECT
);
	// Recent completion strobes, so a flag rise can be traced to its cause.
	logic [5:0] done_reg;
	always @(posedge SYS_CLK) begin
		done_reg <= RSTN ? {done_reg[4:0], MEAS_DONE} : 6'h00;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	sequence opt_wr;
		REG_WR && REG_ADDR == 8'h3a ##1 !REG_WR;
	endsequence
	a_flag_cause: assert property ($rose(CARD_SENSE_IRQ_FLAG) |-> |done_reg)
		else $error("flag rose without a completion");
	a_flag_release: assert property ($fell(CARD_SENSE_IRQ_FLAG) |-> $past(IRQ_FLAG_CLR, 2) || $past(IRQ_FLAG_CLR, 3))
		else $error("flag fell without a clear");
	a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");
	a_drive_write: assert property (opt_wr |=> FULL_DRIVE_DURING_DETECT == (NEW_VARIANT != 0 && $past(REG_WDATA[3], 2)))
		else $error("drive level does not follow options write");
	a_drive_steady: assert property ($changed(FULL_DRIVE_DURING_DETECT) |-> $past(REG_WR) || $past(REG_WR, 2))
		else $error("drive level changed without a write");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR == 8'h50 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_result_rsv: assert property (REG_RD && REG_ADDR == 8'h42 |=> REG_RDATA[7:6] == 2'b00)
		else $error("in-phase result reserved bits set");
	a_quad_rsv: assert property (REG_RD && REG_ADDR == 8'h43 |=> !REG_RDATA[7])
		else $error("quadrature result reserved bit set");
endmodule
bind lcs_threshold_unit lcs_chk #(.NEW_VARIANT(NEW_VARIANT)) lcs_chk_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.MEAS_DONE(MEAS_DONE), .CARD_SENSE_IRQ_FLAG(CARD_SENSE_IRQ_FLAG), .IRQ_FLAG_CLR(IRQ_FLAG_CLR),
	.FULL_DRIVE_DURING_DETECT(FULL_DRIVE_DURING_DETECT));

// file: verif/lcs_front_model.sv
// Behavioural antenna front end that plays one card sense measurement.
`timescale 1ns/1ps
module lcs_front_model (
	input  wire        clk,
	output logic       start = 1'b0,
	output logic       smp = 1'b0,
	output logic       done = 1'b0,
	output logic [5:0] i_val = 6'h00,
	output logic [5:0] q_val = 6'h00
);
	// Two samples, the second may differ; w idle cycles pass before completion.
	task automatic measure(input logic [5:0] i0, q0, i1, q1, input int w);
		@(negedge clk);
		start = 1'b1;
		i_val = i0;
		q_val = q0;
		repeat (4) @(negedge clk);
		smp = 1'b1;
		repeat (4) @(negedge clk);
		smp = 1'b0;
		i_val = i1;
		q_val = q1;
		repeat (4) @(negedge clk);
		smp = 1'b1;
		repeat (4) @(negedge clk);
		smp = 1'b0;
		repeat (w) @(negedge clk);
		done = 1'b1;
		repeat (4) @(negedge clk);
		done = 1'b0;
		start = 1'b0;
		i_val = ~i1;
		q_val = ~q1;
		repeat (4) @(negedge clk);
	endtask
endmodule

// file: verif/tb_top.sv
// Self-checking testbench of the card sense threshold unit.
`timescale 1ns/1ps
module tb_top;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       wr_s = 1'b0;
	logic       rd_s = 1'b0;
	logic       clr = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	wire  [7:0] rdata;
	wire  [5:0] mi, mq;
	wire        st, smp, dn, flag, drv, ovr;
	wire  [7:0] rdata_old;
	wire        drv_old;
	int         n_mismatch = 0;
	int         compares = 0;
	initial forever #2 clk = ~clk;
	lcs_threshold_unit #(.NEW_VARIANT(1)) lcs_threshold_unit_i (.SYS_CLK(clk), .RSTN(rstn), .REG_ADDR(addr),
		.REG_WR(wr_s), .REG_RD(rd_s), .REG_WDATA(wdata), .REG_RDATA(rdata), .MEAS_START(st), .MEAS_SAMPLE(smp),
		.MEAS_I(mi), .MEAS_Q(mq), .MEAS_DONE(dn), .CARD_SENSE_IRQ_FLAG(flag), .IRQ_FLAG_CLR(clr),
		.FULL_DRIVE_DURING_DETECT(drv), .SAMPLE_OVERRUN(ovr));
	lcs_threshold_unit #(.NEW_VARIANT(0)) lcs_threshold_unit_old_i (.SYS_CLK(clk), .RSTN(rstn), .REG_ADDR(addr),
		.REG_WR(wr_s), .REG_RD(rd_s), .REG_WDATA(wdata), .REG_RDATA(rdata_old), .MEAS_START(st), .MEAS_SAMPLE(smp),
		.MEAS_I(mi), .MEAS_Q(mq), .MEAS_DONE(dn), .CARD_SENSE_IRQ_FLAG(), .IRQ_FLAG_CLR(clr),
		.FULL_DRIVE_DURING_DETECT(drv_old), .SAMPLE_OVERRUN());
	lcs_front_model lcs_front_model_i (.clk(clk), .start(st), .smp(smp), .done(dn), .i_val(mi), .q_val(mq));
	task chk(input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t ns: got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(negedge clk) addr = a;
		wdata = d;
		wr_s = 1'b1;
		@(negedge clk) wr_s = 1'b0;
	endtask
	task rd(input logic [7:0] a, m, e);
		@(negedge clk) addr = a;
		rd_s = 1'b1;
		@(negedge clk) rd_s = 1'b0;
		chk(rdata & m, e);
	endtask
	task go(input logic [5:0] i0, q0, i1, q1, input int w, input logic h);
		@(negedge clk);
		clr = 1'b1;
		@(negedge clk);
		clr = 1'b0;
		repeat (3) @(negedge clk);
		lcs_front_model_i.measure(i0, q0, i1, q1, w);
		chk({7'h0, flag}, {7'h0, h});
	endtask
	task tally_and_finish;
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish;
	end
	initial begin
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		wr(8'h3f, 8'h80);
		wr(8'h40, 8'h5e);
		wr(8'h41, 8'hc5);
		wr(8'h42, 8'hff);
		wr(8'h50, 8'hff);
		rd(8'h3f, 8'hff, 8'h80);
		rd(8'h40, 8'hff, 8'h5e);
		rd(8'h41, 8'hff, 8'hc5);
		rd(8'h42, 8'hff, 8'h00);
		rd(8'h50, 8'hff, 8'h00);
		go(6'h27, 6'h1e, 6'h27, 6'h1e, 4, 1'b0);
		rd(8'h42, 8'hff, 8'h27);
		go(6'h28, 6'h00, 6'h28, 6'h00, 4, 1'b1);
		go(6'h10, 6'h1f, 6'h10, 6'h1f, 4, 1'b1);
		go(6'h04, 6'h10, 6'h04, 6'h10, 4, 1'b1);
		go(6'h05, 6'h1e, 6'h05, 6'h1e, 4, 1'b0);
		rd(8'h43, 8'hbf, 8'h1e);
		fork
			go(6'h30, 6'h00, 6'h30, 6'h00, 4, 1'b0);
			begin
				repeat (14) @(negedge clk);
				wr(8'h43, 8'h40);
			end
		join
		rd(8'h43, 8'hc0, 8'h40);
		go(6'h30, 6'h00, 6'h30, 6'h00, 4, 1'b1);
		rd(8'h43, 8'hc0, 8'h00);
		wr(8'h3a, 8'hff);
		rd(8'h3a, 8'hfc, 8'h0c);
		chk(rdata_old, 8'h00);
		chk({7'h0, drv_old}, 8'h00);
		chk({7'h0, drv}, 8'h01);
		wr(8'h3a, 8'h04);
		rd(8'h3a, 8'hfc, 8'h04);
		chk({7'h0, drv}, 8'h00);
		go(6'h05, 6'h05, 6'h06, 6'h05, 4, 1'b0);
		rd(8'h3a, 8'h03, 8'h01);
		go(6'h05, 6'h05, 6'h05, 6'h06, 4, 1'b0);
		rd(8'h3a, 8'h03, 8'h02);
		go(6'h30, 6'h05, 6'h30, 6'h05, 4, 1'b1);
		rd(8'h3a, 8'h03, 8'h00);
		go(6'h05, 6'h05, 6'h05, 6'h05, 1200, 1'b0);
		chk({7'h0, ovr}, 8'h01);
		go(6'h05, 6'h05, 6'h05, 6'h05, 4, 1'b0);
		chk({7'h0, ovr}, 8'h00);
		tally_and_finish;
	end
endmodule
